// ### src/state_counter_pkg.sv
/*
 * Constants for the eight-state low power state counter: coding styles,
 * state codes per coding and reset values.
 * Assumes nothing of its surroundings.
 */
package state_counter_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Coding styles
    typedef enum logic [1:0]
    {
        CODE_ONE_HOT,
        CODE_GRAY,
        CODE_BINARY,
        CODE_LFSR
    } coding_t;

    localparam int NUM_STATES  = 8;
    localparam int CODE_BITS   = 3;
    localparam int HOT_BITS    = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // State codes S0..S7 per coding (index 0 = S0)
    localparam logic [CODE_BITS-1:0] GRAY_SEQ [NUM_STATES] =
        '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
    localparam logic [CODE_BITS-1:0] BIN_SEQ [NUM_STATES] =
        '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    localparam logic [CODE_BITS-1:0] LFSR_SEQ [NUM_STATES] =
        '{3'h7, 3'h6, 3'h4, 3'h0, 3'h1, 3'h2, 3'h5, 3'h3};

    // Reset value of the one-hot register (S0)
    localparam logic [HOT_BITS-1:0] HOT_RESET = 8'h01;

endpackage : state_counter_pkg

// ### src/low_power_state_counter.sv
/*
 * Eight-state counter with build-time choice of state coding (one-hot,
 * Gray, binary, shift register) and one-hot Moore output decoding.
 * The one-hot ring and the three-bit code register are both present;
 * only the one picked by CODING moves, the other stays parked at S0.
 * Moore outputs are decoded from the ring and registered, so every
 * output port comes straight from a flip-flop.
 * Assumes one clock, inputs synchronous to it, synchronous active-low reset.
 * Assumes countEn is a plain level; no edge detection is done on it.
 * Assumes the integrator picks the coding: one-hot for sparse outputs,
 * Gray for plain counters and address counters.
 * Assumes OUT_MASK gives each output at least one active state.
 */
// How it works
// - Gray follows 000,001,011,010,110,111,101,100; binary counts 000 to 111.
// - Shift-register coding follows 111,110,100,000,001,010,101,011 then wraps.
// - Gray changes one bit per clock, eight per cycle, three flip-flops.
// - One-hot uses eight flip-flops, one set, moving one place per state.
// - Each Moore output is the OR of hot bits of states where it is active.
// - A one-hot transition changes only the cleared and the set flip-flop.
`timescale 1ns/100ps

module low_power_state_counter
    import state_counter_pkg::*;
#(
    parameter coding_t             CODING   = CODE_GRAY,
    parameter int                  NUM_OUTS = 4,
    // Per output, the set of states in which it is active
    parameter logic [HOT_BITS-1:0] OUT_MASK [NUM_OUTS] = '{8'h01, 8'h0C, 8'h30, 8'h80}
)
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  countEn,
    output logic      [HOT_BITS-1:0]   hotStateBit,
    output logic      [CODE_BITS-1:0]  stateCode,
    output logic      [NUM_OUTS-1:0]   mooreOut
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // At least one Moore output
    if (NUM_OUTS < 1)
    begin : gen_chk_outs
        $error("NUM_OUTS must be at least 1");
    end

    // The one-hot ring needs one flip-flop per state
    if (HOT_BITS != NUM_STATES)
    begin : gen_chk_hot
        $error("HOT_BITS must equal NUM_STATES");
    end

    // The encoded register must hold every state code
    if ((1 << CODE_BITS) < NUM_STATES)
    begin : gen_chk_code
        $error("CODE_BITS too narrow for NUM_STATES");
    end

    // Every Moore output must be active in at least one state
    for (genvar m = 0; m < NUM_OUTS; m++)
    begin : gen_chk_mask
        if (OUT_MASK[m] == '0)
        begin : gen_chk_mask_zero
            $error("OUT_MASK entry selects no state");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    // Next code in the encoded sequence; an unlisted code holds
    function automatic logic [CODE_BITS-1:0] nextCode(input logic [CODE_BITS-1:0] cur,
                                                       input coding_t              cod);
        logic [CODE_BITS-1:0] res;
        res = cur;
        for (int i = 0; i < NUM_STATES; i++)
        begin
            case (cod)
                CODE_GRAY:
                begin
                    if (GRAY_SEQ[i] == cur)
                        res = GRAY_SEQ[(i + 1) % NUM_STATES];
                end
                CODE_LFSR:
                begin
                    if (LFSR_SEQ[i] == cur)
                        res = LFSR_SEQ[(i + 1) % NUM_STATES];
                end
                default:
                begin
                    if (BIN_SEQ[i] == cur)
                        res = BIN_SEQ[(i + 1) % NUM_STATES];
                end
            endcase
        end
        return res;
    endfunction : nextCode

    // Code of state S0 for a coding; one-hot parks the code at zero
    function automatic logic [CODE_BITS-1:0] firstCode(input coding_t cod);
        logic [CODE_BITS-1:0] res;
        case (cod)
            CODE_GRAY: res = GRAY_SEQ[0];
            CODE_LFSR: res = LFSR_SEQ[0];
            default:   res = BIN_SEQ[0];
        endcase
        return res;
    endfunction : firstCode

    // One ring step: the set bit moves one place up, the top bit wraps to bit 0
    function automatic logic [HOT_BITS-1:0] rotateHot(input logic [HOT_BITS-1:0] cur);
        return {cur[HOT_BITS-2:0], cur[HOT_BITS-1]};
    endfunction : rotateHot

    // Moore decode: OR of the hot bits of the states where an output is active
    function automatic logic [NUM_OUTS-1:0] mooreDecode(input logic [HOT_BITS-1:0] hot);
        logic [NUM_OUTS-1:0] res;
        res = '0;
        for (int k = 0; k < NUM_OUTS; k++)
        begin
            res[k] = |(hot & OUT_MASK[k]);
        end
        return res;
    endfunction : mooreDecode

    ////////////////////////////////////////////////////////////////////////////////
    // State and output registers

    logic [HOT_BITS-1:0]  hot_q;
    logic [CODE_BITS-1:0] code_q;
    logic [NUM_OUTS-1:0]  out_q;
    logic [HOT_BITS-1:0]  hot_d;
    logic [CODE_BITS-1:0] code_d;
    logic [NUM_OUTS-1:0]  out_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Ring moves only in one-hot coding and only while enabled
    always_comb
    begin
        hot_d = hot_q;
        if ((CODING == CODE_ONE_HOT) && countEn)
        begin
            hot_d = rotateHot(hot_q);
        end
    end

    // Code register steps in the encoded codings only, while enabled
    always_comb
    begin
        code_d = code_q;
        if ((CODING != CODE_ONE_HOT) && countEn)
        begin
            code_d = nextCode(code_q, CODING);
        end
    end

    // Outputs decoded from the next ring value, so they line up with hot_q
    always_comb
    begin
        out_d = mooreDecode(hot_d);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    // One-hot ring; stays at S0 in the encoded codings
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hot_q <= HOT_RESET;
        end
        else
        begin
            hot_q <= hot_d;
        end
    end

    // Encoded three-bit state; S0 of the chosen coding after reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            code_q <= firstCode(CODING);
        end
        else
        begin
            code_q <= code_d;
        end
    end

    // Moore output flops; reset value is the decode of the S0 ring
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            out_q <= mooreDecode(HOT_RESET);
        end
        else
        begin
            out_q <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Ports straight from the flip-flops

    assign hotStateBit = hot_q;
    assign stateCode   = code_q;
    assign mooreOut    = out_q;

endmodule : low_power_state_counter

// ### testbench/state_counter_chk.sv
/* Checker for the state counter ports.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module state_counter_chk
    import state_counter_pkg::*;
#(parameter coding_t CODING = CODE_GRAY, parameter int NUM_OUTS = 4,
  parameter logic [HOT_BITS-1:0] OUT_MASK [NUM_OUTS] = '{default: 8'h00})
(input wire logic clk, input wire logic rst_n, input wire logic countEn,
 input wire logic [HOT_BITS-1:0] hotStateBit,
 input wire logic [CODE_BITS-1:0] stateCode, input wire logic [NUM_OUTS-1:0] mooreOut);
////////
// Expected Moore outputs and S0 code
logic [NUM_OUTS-1:0] expMo;
logic [CODE_BITS-1:0] s0;
always_comb for (int k = 0; k < NUM_OUTS; k++) expMo[k] = |(hotStateBit & OUT_MASK[k]);
assign s0 = (CODING == CODE_LFSR) ? 3'h7 : 3'h0;
default clocking cb @(posedge clk); endclocking
sequence stepS; rst_n && countEn; endsequence
////////
AST_RESET: assert property (!rst_n |=> stateCode == s0 && hotStateBit == 8'h01)
    else $error("reset state wrong");
AST_HOLD: assert property (disable iff (!rst_n) !countEn |=> $stable(stateCode)
    && $stable(hotStateBit)) else $error("state moved while disabled");
AST_GRAY: assert property (disable iff (!rst_n) stepS ##0 (CODING == CODE_GRAY)
    |=> $countones(stateCode ^ $past(stateCode)) == 1) else $error("gray step not one bit");
AST_BIN: assert property (disable iff (!rst_n) stepS ##0 (CODING == CODE_BINARY)
    |=> stateCode == $past(stateCode) + 3'h1) else $error("binary step wrong");
AST_LFSR: assert property (disable iff (!rst_n) stepS ##0 (CODING == CODE_LFSR)
    ##0 (stateCode == 3'h3) |=> stateCode == 3'h7) else $error("shift code wrap wrong");
AST_HOT1: assert property (disable iff (!rst_n) $onehot(hotStateBit))
    else $error("hot register not one-hot");
AST_HOTSTEP: assert property (disable iff (!rst_n) stepS ##0 (CODING == CODE_ONE_HOT)
    |=> {hotStateBit[0], hotStateBit[7:1]} == $past(hotStateBit)) else $error("hot step wrong");
AST_MOORE: assert property (disable iff (!rst_n) mooreOut == expMo)
    else $error("moore output wrong");
endmodule : state_counter_chk
bind low_power_state_counter state_counter_chk #(.CODING(CODING), .NUM_OUTS(NUM_OUTS),
    .OUT_MASK(OUT_MASK)) state_counter_chk_i (.clk(clk), .rst_n(rst_n), .countEn(countEn),
    .hotStateBit(hotStateBit), .stateCode(stateCode), .mooreOut(mooreOut));

// ### testbench/tb_low_power_state_counter.sv
/* Bench running all four codings side by side.
   Assumes the checker is bound to every counter. */
`timescale 1ns/100ps
module tb_low_power_state_counter
    import state_counter_pkg::*;
;
localparam logic [7:0] MSK [4] = '{8'h01, 8'h0C, 8'h30, 8'h80}; // Sparse outputs
logic clk = 1'b0, rst_n = 1'b0, countEn = 1'b0;
logic [7:0] hot [4], eh;
logic [2:0] code [4];
logic [3:0] mo [4];
logic [31:0] rng = 32'h0000000B;
int n_mismatch = 0, num_checks = 0, idx = 0;
for (genvar g = 0; g < 4; g++) // Gray used as plain counter only
begin : gen_c
    low_power_state_counter #(.CODING(coding_t'(g)), .NUM_OUTS(4), .OUT_MASK(MSK))
        low_power_state_counter_i (.clk(clk),
        .rst_n(rst_n), .countEn(countEn), .hotStateBit(hot[g]), .stateCode(code[g]),
        .mooreOut(mo[g]));
end
////////
function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
endfunction : xs
function automatic logic [2:0] expCode(int c, int s);
    return (c == 1) ? GRAY_SEQ[s] : (c == 2) ? BIN_SEQ[s] : (c == 3) ? LFSR_SEQ[s] : 3'h0;
endfunction : expCode
function automatic logic [3:0] expMoore(logic [7:0] h);
    for (int k = 0; k < 4; k++) expMoore[k] = |(h & MSK[k]);
endfunction : expMoore
task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
endtask : cmp
task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask : give_verdict
////////
initial forever #25 clk = ~clk;
// Steady count, then random enable, reset again mid-run
initial
begin
    for (int i = 0; i < 320; i++)
    begin
        @(posedge clk);
        if (!rst_n) idx = 0;
        else if (countEn) idx = (idx + 1) % 8;
        rng = xs(rng);
        countEn <= (i < 30) | rng[0];
        rst_n <= !(i < 7 || i == 200 || i == 201);
        @(negedge clk);
        for (int g = 0; g < 4; g++)
        begin
            eh = (g == 0) ? 8'h01 << idx : 8'h01;
            cmp("code", expCode(g, idx), code[g]);
            cmp("hot", eh, hot[g]);
            cmp("moore", expMoore(eh), mo[g]);
        end
    end
    give_verdict();
end
endmodule : tb_low_power_state_counter
